// File: dv/spi_host_model.sv
// host spi controller model: select, serial clock and data lines
module spi_host_model (
   // link pins toward the device
   output logic sel_n_o,
   output logic sclk_o,
   output logic [3:0] io_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // clock stands low and select high outside frames
   initial begin
      sel_n_o = 1'b1;
      sclk_o = 1'b0;
      io_o = 4'h0;
   end
   // data set while clock low, device samples on the rise
   task automatic bit_out(input logic [3:0] v);
      io_o = v;
      #80 sclk_o = 1'b1;
      #80 sclk_o = 1'b0;
   endtask : bit_out
   // bytes msb first on line zero, optional confirm clock
   task automatic frame(input logic [7:0] b[$], input int dummy);
      sel_n_o = 1'b0;
      foreach (b[i]) for (int k = 7; k >= 0; k--) bit_out({3'h0, b[i][k]});
      if (dummy >= 0) bit_out({3'h5, dummy[0]}); // junk on upper lines
      #40 sel_n_o = 1'b1; // select rise confirms
      io_o = ~io_o; // released lines must not look stable
      #200;
   endtask : frame
endmodule : spi_host_model

// File: dv/tb_top.sv
// self-checking bench for the flash command front end
`define CHK(nm, e, a) begin n_checks++; if ((a) !== (e)) begin mismatches++; \
   $display("unexpected %s exp %h got %h", nm, e, a); end end
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import flash_gate_pkg::*;
   logic clk = 1'b0, rst = 1'b1, pe = 1'b0, esusp = 1'b0, rpin_n = 1'b1, got = 1'b0, ev_acc;
   logic ce = 1'b1, psusp = 1'b0, ssusp = 1'b0, a_rdy = 1'b0;
   logic [7:0] a_data = 8'h00;
   logic [3:0] io;
   logic sel_n, sclk, evv, xip, vcfg_n, busy, fail, a_vld, d_rdy;
   cmd_evt_type ev;
   logic [63:0] res;
   logic [31:0] a_addr, first;
   int pend = 0, nreq = 0, mismatches = 0, n_checks = 0;
   always #10 clk = ~clk;
   spi_host_model host (.sel_n_o(sel_n), .sclk_o(sclk), .io_o(io));
   flash_state_gating_xip_crc u_dut (.CORE_CLK_I(clk), .SYS_RST_I(rst), .CE_I(ce), .SEL_N_I(sel_n),
      .SCLK_I(sclk), .IO_LINE_I(io), .RESET_PIN_N_I(rpin_n), .PROTO_WIDTH_I(2'h0), .NVCFG_XIP_I(3'h7),
      .RESET_PIN_EN_I(1'b1), .PE_ACTIVE_I(pe), .PGM_SUSP_I(psusp), .SUB_ERASE_SUSP_I(ssusp),
      .ERASE_SUSP_I(esusp), .SUSP_SECTOR_I(8'h12), .CMD_EVT_VALID_O(evv), .CMD_EVT_O(ev),
      .EXECUTE_IN_PLACE_O(xip), .VCFG_XIP_N_O(vcfg_n), .CRC_BUSY_O(busy), .FLAG_CRC_FAIL_O(fail),
      .CRC_RESULT_REG_O(res), .ARRAY_ADDR_O(a_addr), .ARRAY_ADDR_VALID_O(a_vld), .ARRAY_ADDR_READY_I(a_rdy),
      .ARRAY_DATA_I(a_data), .ARRAY_DATA_VALID_I(pend != 0), .ARRAY_DATA_READY_O(d_rdy));
   // array answers each taken address in order with a_data; events captured
   always @(posedge clk) begin
      pend <= pend + int'(a_vld && a_rdy) - int'(pend != 0 && d_rdy);
      if (evv) ev_acc <= ev.accepted;
      if (a_vld && a_rdy) nreq <= nreq + 1;
      if (a_vld && a_rdy && !got) first <= a_addr;
      if (a_vld && a_rdy) got <= 1'b1;
   end
   // address ready alternates so the request stream sees stalls
   always @(negedge clk) a_rdy <= !a_rdy;
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : conclude
   // reference crc over n copies of one byte, lsb first, zero start
   function automatic logic [63:0] crc_ref(input logic [7:0] d, input int n);
      logic [63:0] c;
      c = 64'h0;
      for (int i = 0; i < 8 * n; i++) c = (c >> 1) ^ (c[0] ^ d[i % 8] ? CRC_POLY_REFL : 64'h0);
      return c;
   endfunction : crc_ref
   task automatic cmd(input logic [7:0] b[$], input int d, input logic a);
      ev_acc = 1'bx;
      host.frame(b, d);
      `CHK("accepted", a, ev_acc)
   endtask : cmd
   task automatic gating();
      logic [7:0] opc[4] = '{OPC_WR_EN, OPC_RD_STATUS, OPC_WR_STATUS, OPC_ERASE_SUSP};
      logic [19:0] exp = 20'b1110_0101_1100_1100_1100;
      for (int s = 0; s < 5; s++) begin
         @(negedge clk);
         pe = (s == 1);
         psusp = (s == 2);
         ssusp = (s == 3);
         esusp = (s == 4);
         for (int o = 0; o < 4; o++) cmd('{opc[o]}, -1, exp[19-4*s-o]);
         cmd('{OPC_READ, 8'h12, 8'h00, 8'h00}, -1, s != 1);
      end
      `CHK("unsure", 1'b1, ev.data_unsure)
      cmd('{OPC_PROGRAM, 8'h12, 8'h00, 8'h00}, -1, 1'b0);
      cmd('{OPC_PROGRAM, 8'h34, 8'h00, 8'h00}, -1, 1'b1);
      `CHK("evt addr", 24'h340000, ev.addr)
      cmd('{OPC_SECT_ERASE, 8'h34, 8'h00, 8'h00}, -1, 1'b0);
      @(negedge clk) esusp = 1'b0;
   endtask : gating
   task automatic crc_check(input logic [7:0] d, input logic f);
      int n = 0;
      logic [63:0] c;
      logic [7:0] q[$];
      c = crc_ref(d, 4);
      q = '{OPC_IF_ACTIVATE, SUB_CRC, OPT_RANGE};
      for (int i = 0; i < 8; i++) q.push_back(c[8*i +: 8] ^ {7'h0, f && i == 0});
      q = {q, 8'h10, 8'h00, 8'h00, 8'h00, 8'h13, 8'h00, 8'h00, 8'h00};
      a_data = d;
      got = 1'b0;
      nreq = 0;
      host.frame(q, -1);
      while (busy !== 1'b0 && n < 200) begin @(negedge clk); n++; end
      if (n == 200) mismatches++;
      `CHK("first addr", 32'h10, first)
      `CHK("requests", 4, nreq)
      `CHK("fail flag", f, fail)
      `CHK("result", f ? c : 64'h0, res)
   endtask : crc_check
   task automatic xip_mode();
      cmd('{OPC_WR_VCFG, 8'hf7}, -1, 1'b1);
      `CHK("vcfg bit", 1'b0, vcfg_n)
      cmd('{OPC_FAST_READ, 8'h00, 8'h00, 8'h00}, 0, 1'b1);
      `CHK("xip on", 1'b1, xip)
      host.frame('{8'h00, 8'h01, 8'h02}, 0);
      `CHK("xip kept", 1'b1, xip)
      // a pin pulse while the clock enable is low must not be seen
      @(negedge clk) ce = 1'b0;
      rpin_n = 1'b0;
      repeat (6) @(negedge clk);
      rpin_n = 1'b1;
      @(negedge clk) ce = 1'b1;
      repeat (4) @(negedge clk);
      `CHK("xip frozen", 1'b1, xip)
      @(negedge clk) rpin_n = 1'b0;
      repeat (6) @(negedge clk);
      rpin_n = 1'b1;
      `CHK("xip pin reset", 1'b0, xip)
      cmd('{OPC_WR_VCFG, 8'hf7}, -1, 1'b1);
      cmd('{OPC_FAST_READ, 8'h00, 8'h00, 8'h00}, 0, 1'b1);
      host.frame('{8'h00, 8'h01, 8'h02}, 1);
      `CHK("xip off", 1'b0, xip)
      `CHK("vcfg restored", 1'b1, vcfg_n)
   endtask : xip_mode
   // reset, then the scenarios in turn
   initial begin
      repeat (16) @(posedge clk);
      @(negedge clk) rst = 1'b0;
      repeat (4) @(negedge clk);
      `CHK("boot xip", 1'b0, xip)
      gating();
      crc_check(8'ha5, 1'b1);
      crc_check(8'h3c, 1'b0);
      xip_mode();
      conclude();
   end
endmodule : tb_top

// File: hdl/flash_gate_pkg.sv
// shared constants and types for the flash command front end
package flash_gate_pkg;
   // crc sequence codes
   localparam logic [7:0] OPC_IF_ACTIVATE = 8'h9b;
   localparam logic [7:0] SUB_CRC = 8'h27;
   localparam logic [7:0] OPT_RANGE = 8'hfe;
   localparam logic [7:0] OPT_WHOLE = 8'hff;
   localparam logic [7:0] OPC_RD_CRC_RES = 8'h96;
   // other opcodes: plain defaults, adjust to the part
   localparam logic [7:0] OPC_READ = 8'h03;
   localparam logic [7:0] OPC_FAST_READ = 8'h0b;
   localparam logic [7:0] OPC_RD_STATUS = 8'h05;
   localparam logic [7:0] OPC_RD_FLAG = 8'h70;
   localparam logic [7:0] OPC_PROGRAM = 8'h02;
   localparam logic [7:0] OPC_SECT_ERASE = 8'hd8;
   localparam logic [7:0] OPC_SUB_ERASE = 8'h20;
   localparam logic [7:0] OPC_WR_STATUS = 8'h01;
   localparam logic [7:0] OPC_WR_NVCFG = 8'hb1;
   localparam logic [7:0] OPC_PROG_OTP = 8'h42;
   localparam logic [7:0] OPC_BULK_ERASE = 8'hc7;
   localparam logic [7:0] OPC_WR_VCFG = 8'h81;
   localparam logic [7:0] OPC_WR_EVCFG = 8'h61;
   localparam logic [7:0] OPC_WR_EN = 8'h06;
   localparam logic [7:0] OPC_WR_DIS = 8'h04;
   localparam logic [7:0] OPC_CLR_FLAG = 8'h50;
   localparam logic [7:0] OPC_WR_LOCK = 8'he5;
   localparam logic [7:0] OPC_PROG_SUSP = 8'h75;
   localparam logic [7:0] OPC_ERASE_SUSP = 8'hb0;
   // crc sequence byte positions, counted from one
   localparam logic [4:0] SEQ_EXP_FIRST = 5'h04;
   localparam logic [4:0] SEQ_EXP_LAST = 5'h0b;
   localparam logic [4:0] SEQ_START_FIRST = 5'h0c;
   localparam logic [4:0] SEQ_START_LAST = 5'h0f;
   localparam logic [4:0] SEQ_STOP_FIRST = 5'h10;
   localparam logic [4:0] SEQ_STOP_LAST = 5'h13;
   // ecma generator, bit reversed for lsb-first feeding
   localparam logic [63:0] CRC_POLY_REFL = 64'hc96c5795d7870f42;
   localparam logic [63:0] CRC_INIT = 64'h0;
   // config fields and layout
   localparam int VCFG_XIP_BIT = 3;
   localparam logic [2:0] NVCFG_XIP_OFF = 3'h7;
   localparam int SECTOR_LSB = 16;
   localparam logic [1:0] ADDR_BYTES = 2'h3;
   localparam logic [1:0] PROTO_SINGLE = 2'h0;
   localparam logic [1:0] PROTO_DUAL = 2'h1;
   localparam logic [1:0] PROTO_QUAD = 2'h2;

   typedef enum logic [3:0] {
      ST_STANDBY = 4'b0001, ST_BUSY = 4'b0010, ST_SUSP = 4'b0100, ST_ERASE_SUSP = 4'b1000
   } dev_state_type;
   typedef enum logic [7:0] {
      CL_READ = 8'h01, CL_STATUS = 8'h02, CL_PROG = 8'h04, CL_ERASE = 8'h08,
      CL_WRITE_NV = 8'h10, CL_WRITE_V = 8'h20, CL_SUSPEND = 8'h40, CL_OTHER = 8'h80
   } op_class_type;
   typedef enum logic [5:0] {
      PH_OPC = 6'b000001, PH_ADDR = 6'b000010, PH_DUMMY = 6'b000100,
      PH_DATA = 6'b001000, PH_CRC = 6'b010000, PH_IGNORE = 6'b100000
   } phase_type;
   typedef struct packed {
      logic [7:0] opcode;
      logic [23:0] addr;
      op_class_type cls;
      dev_state_type state;
      logic accepted;
      logic data_unsure;
   } cmd_evt_type;
endpackage : flash_gate_pkg

// File: hdl/flash_state_gating_xip_crc.sv
// command front end: crc check sequence, state gating and execute-in-place control
// How it works
// - crc check opens with activation opcode, crc sub-command, then range or whole-device option
// - bytes four to eleven form the 64-bit expected crc, low byte first
// - bytes twelve to fifteen form the start address, low byte first
// - bytes sixteen to nineteen form the last address, low byte first
// - the check starts only on select rising after the final byte
// - one device state at a time; standby takes all but suspend
// - in erase suspend, program to the suspended sector is refused
// - array reads accepted in standby and suspends, refused while busy
// - reads into a suspended-erase sector are accepted but flagged unsure
// - status and flag status reads are accepted in every state
// - sector and subsector erase accepted only in standby
// - status, nonvolatile, otp writes and bulk erase only in standby
// - volatile writes, enables, flag clear, lock writes refused only while busy
// - suspend requests accepted only while busy: a program, erase or crc check runs
// - array program in standby and erase suspend, refused elsewhere
// - clearing volatile bit 3 then confirm zero in fast read enters xip
// - in xip each select frame starts with address, no opcode
// - confirm one leaves xip and sets volatile bit 3 again
// - nonvolatile bits 11 to 9 can start the device in xip
// - confirm bit is line zero on the first dummy clock
// - lines one to three are ignored on that dummy clock
// - reset pin low restores nonvolatile xip state, in quad only deselected
// - crc-64 ecma, lsb first, zero initial value
// - compare result drives the crc fail flag bit
// - result register cleared at start, loaded with crc only on failure
// - whole-device option ends the sequence after the expected crc
module flash_state_gating_xip_crc
   import flash_gate_pkg::*;
#(
   parameter int SECT_W = 8,
   parameter int FIFO_DEPTH = 8,
   parameter logic [31:0] DEV_LAST_ADDR = 32'h00ff_ffff
) (
   // clock, reset, enable
   input wire logic CORE_CLK_I,
   input wire logic SYS_RST_I,
   input wire logic CE_I,
   // serial link pins
   input wire logic SEL_N_I,
   input wire logic SCLK_I,
   input wire logic [3:0] IO_LINE_I,
   input wire logic RESET_PIN_N_I,
   // configuration and device state
   input wire logic [1:0] PROTO_WIDTH_I,
   input wire logic [2:0] NVCFG_XIP_I,
   input wire logic RESET_PIN_EN_I,
   input wire logic PE_ACTIVE_I,
   input wire logic PGM_SUSP_I,
   input wire logic SUB_ERASE_SUSP_I,
   input wire logic ERASE_SUSP_I,
   input wire logic [SECT_W-1:0] SUSP_SECTOR_I,
   // decoded command events
   output logic CMD_EVT_VALID_O,
   output cmd_evt_type CMD_EVT_O,
   // execute-in-place status
   output logic EXECUTE_IN_PLACE_O,
   output logic VCFG_XIP_N_O,
   // crc engine results
   output logic CRC_BUSY_O,
   output logic FLAG_CRC_FAIL_O,
   output logic [63:0] CRC_RESULT_REG_O,
   // array read stream for the crc engine
   output logic [31:0] ARRAY_ADDR_O,
   output logic ARRAY_ADDR_VALID_O,
   input wire logic ARRAY_ADDR_READY_I,
   input wire logic [7:0] ARRAY_DATA_I,
   input wire logic ARRAY_DATA_VALID_I,
   output logic ARRAY_DATA_READY_O
);
   initial begin
      if (SECT_W < 1 || SECT_W > 24 - SECTOR_LSB) $error("SECT_W out of range");
   end

   // one reflected crc-64 step over a byte, lsb first
   function automatic logic [63:0] crc_byte(input logic [63:0] c, input logic [7:0] d);
      logic [63:0] r;
      r = c;
      for (int i = 0; i < 8; i++) begin
         if (r[0] ^ d[i]) r = (r >> 1) ^ CRC_POLY_REFL;
         else r = r >> 1;
      end
      return r;
   endfunction : crc_byte

   function automatic op_class_type op_class(input logic [7:0] o);
      case (o)
         OPC_READ, OPC_FAST_READ: return CL_READ;
         OPC_RD_STATUS, OPC_RD_FLAG: return CL_STATUS;
         OPC_PROGRAM: return CL_PROG;
         OPC_SECT_ERASE, OPC_SUB_ERASE: return CL_ERASE;
         OPC_WR_STATUS, OPC_WR_NVCFG, OPC_PROG_OTP, OPC_BULK_ERASE: return CL_WRITE_NV;
         OPC_WR_VCFG, OPC_WR_EVCFG, OPC_WR_EN, OPC_WR_DIS, OPC_CLR_FLAG, OPC_WR_LOCK: return CL_WRITE_V;
         OPC_PROG_SUSP, OPC_ERASE_SUSP: return CL_SUSPEND;
         default: return CL_OTHER;
      endcase
   endfunction : op_class

   // permission per class and state; same_sect only matters in erase suspend
   function automatic logic op_allowed(input op_class_type c, input dev_state_type s, input logic same_sect);
      unique case (c)
         CL_READ: return s != ST_BUSY;
         CL_STATUS: return 1'b1;
         CL_PROG: return s == ST_STANDBY || (s == ST_ERASE_SUSP && !same_sect);
         CL_ERASE: return s == ST_STANDBY;
         CL_WRITE_NV: return s == ST_STANDBY;
         CL_WRITE_V: return s != ST_BUSY;
         CL_SUSPEND: return s == ST_BUSY;
         default: return 1'b1;
      endcase
   endfunction : op_allowed

   // two-flop capture of every pin; stage one feeds stage two only
   logic [6:0] pin_s1_r, pin_s2_r;
   logic sel_d_r, sclk_d_r;
   always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         pin_s1_r <= 7'h61;
         pin_s2_r <= 7'h61;
         sel_d_r <= 1'b1;
         sclk_d_r <= 1'b0;
      end else if (CE_I) begin
         pin_s1_r <= {RESET_PIN_N_I, SEL_N_I, SCLK_I, IO_LINE_I};
         pin_s2_r <= pin_s1_r;
         sel_d_r <= pin_s2_r[5];
         sclk_d_r <= pin_s2_r[4];
      end
   end

   logic sel_low, sel_rise, clk_rise, rst_pin_low;
   logic [3:0] io_s;
   assign io_s = pin_s2_r[3:0];
   assign sel_low = !pin_s2_r[5];
   assign sel_rise = pin_s2_r[5] && !sel_d_r;
   assign clk_rise = CE_I && sel_low && pin_s2_r[4] && !sclk_d_r;
   assign rst_pin_low = RESET_PIN_EN_I && !pin_s2_r[6];

   // one operating state, busy wins over any suspend
   dev_state_type dev_state;
   logic crc_busy_r;
   always_comb begin
      if (PE_ACTIVE_I || crc_busy_r) dev_state = ST_BUSY;
      else if (ERASE_SUSP_I) dev_state = ST_ERASE_SUSP;
      else if (PGM_SUSP_I || SUB_ERASE_SUSP_I) dev_state = ST_SUSP;
      else dev_state = ST_STANDBY;
   end

   // bit assembly at the enabled width
   phase_type phase_r;
   logic [7:0] shift_r, byte_v, opcode_r;
   logic [2:0] bit_cnt_r;
   logic [3:0] step;
   logic byte_fire, xip_r, vcr3_r;
   always_comb begin
      unique case (PROTO_WIDTH_I)
         PROTO_DUAL: begin
            step = 4'h2;
            byte_v = {shift_r[5:0], io_s[1:0]};
         end
         PROTO_QUAD: begin
            step = 4'h4;
            byte_v = {shift_r[3:0], io_s};
         end
         default: begin
            step = 4'h1;
            byte_v = {shift_r[6:0], io_s[0]};
         end
      endcase
   end
   assign byte_fire = clk_rise && !(phase_r inside {PH_DUMMY, PH_IGNORE}) && ({1'b0, bit_cnt_r} + step == 4'h8);

   // frame decode
   logic [1:0] addr_cnt_r;
   logic [23:0] addr_r, addr_nxt;
   logic [4:0] seq_idx_r;
   logic crc_whole_r, crc_ok_r;
   logic [63:0] exp_r;
   logic [31:0] start_r, stop_r;
   op_class_type cls_now;
   logic same_sect, evt_fire, evt_ok, addr_done;
   assign addr_nxt = {addr_r[15:0], byte_v};
   assign addr_done = phase_r == PH_ADDR && byte_fire && addr_cnt_r == ADDR_BYTES - 2'h1;
   assign cls_now = xip_r && phase_r != PH_OPC ? CL_READ : op_class(phase_r == PH_OPC ? byte_v : opcode_r);
   assign same_sect = addr_nxt[SECTOR_LSB +: SECT_W] == SUSP_SECTOR_I;
   // opcode-only commands decide at the opcode, addressed ones once the address is in
   assign evt_fire = byte_fire && ((phase_r == PH_OPC && !(cls_now inside {CL_READ, CL_PROG, CL_ERASE}))
                                   || addr_done);
   assign evt_ok = op_allowed(cls_now, dev_state, same_sect);

   always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         phase_r <= PH_OPC;
         shift_r <= 8'h00;
         bit_cnt_r <= 3'h0;
         opcode_r <= 8'h00;
         addr_cnt_r <= 2'h0;
         addr_r <= 24'h0;
      end else if (CE_I) begin
         if (!sel_low) begin
            phase_r <= xip_r ? PH_ADDR : PH_OPC;
            bit_cnt_r <= 3'h0;
            addr_cnt_r <= 2'h0;
            opcode_r <= xip_r ? OPC_FAST_READ : 8'h00;
         end else if (clk_rise && phase_r == PH_DUMMY) begin
            phase_r <= PH_IGNORE;
         end else if (clk_rise && phase_r != PH_IGNORE) begin
            shift_r <= byte_v;
            bit_cnt_r <= 3'(bit_cnt_r + step[2:0]);
            if (byte_fire) begin
               unique case (phase_r)
                  PH_OPC: begin
                     opcode_r <= byte_v;
                     if (byte_v == OPC_IF_ACTIVATE) phase_r <= PH_CRC;
                     else if (cls_now inside {CL_READ, CL_PROG, CL_ERASE}) phase_r <= PH_ADDR;
                     else if (byte_v == OPC_WR_VCFG && evt_ok) phase_r <= PH_DATA;
                     else phase_r <= PH_IGNORE;
                  end
                  PH_ADDR: begin
                     addr_r <= addr_nxt;
                     addr_cnt_r <= addr_cnt_r + 2'h1;
                     if (addr_done) phase_r <= opcode_r == OPC_FAST_READ && evt_ok ? PH_DUMMY : PH_IGNORE;
                  end
                  default: phase_r <= phase_r == PH_CRC ? PH_CRC : PH_IGNORE;
               endcase
            end
         end
      end
   end

   // crc sequence capture, byte index counted from the opcode
   always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         seq_idx_r <= 5'h0;
         crc_ok_r <= 1'b0;
         crc_whole_r <= 1'b0;
         exp_r <= 64'h0;
         start_r <= 32'h0;
         stop_r <= 32'h0;
      end else if (CE_I) begin
         if (!sel_low) begin
            seq_idx_r <= 5'h0;
         end else if (byte_fire && phase_r == PH_OPC) begin
            seq_idx_r <= 5'h1;
            crc_ok_r <= byte_v == OPC_IF_ACTIVATE;
         end else if (byte_fire && phase_r == PH_CRC) begin
            seq_idx_r <= seq_idx_r == 5'h1f ? seq_idx_r : seq_idx_r + 5'h1;
            if (seq_idx_r == 5'h1 && byte_v != SUB_CRC) crc_ok_r <= 1'b0;
            if (seq_idx_r == 5'h2) begin
               crc_ok_r <= crc_ok_r && (byte_v == OPT_RANGE || byte_v == OPT_WHOLE);
               crc_whole_r <= byte_v == OPT_WHOLE;
            end
            if (seq_idx_r + 5'h1 >= SEQ_EXP_FIRST && seq_idx_r + 5'h1 <= SEQ_EXP_LAST)
               exp_r <= {byte_v, exp_r[63:8]};
            if (seq_idx_r + 5'h1 >= SEQ_START_FIRST && seq_idx_r + 5'h1 <= SEQ_START_LAST)
               start_r <= {byte_v, start_r[31:8]};
            if (seq_idx_r + 5'h1 >= SEQ_STOP_FIRST && seq_idx_r + 5'h1 <= SEQ_STOP_LAST)
               stop_r <= {byte_v, stop_r[31:8]};
         end
      end
   end

   // a frame with the right length arms the check at select release
   logic crc_go;
   assign crc_go = CE_I && sel_rise && crc_ok_r && dev_state == ST_STANDBY &&
                   seq_idx_r == (crc_whole_r ? SEQ_EXP_LAST : SEQ_STOP_LAST);

   // command events, registered for the array side
   always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         CMD_EVT_VALID_O <= 1'b0;
         CMD_EVT_O <= '{opcode: 8'h00, addr: 24'h0, cls: CL_OTHER, state: ST_STANDBY,
                        accepted: 1'b0, data_unsure: 1'b0};
      end else if (CE_I) begin
         CMD_EVT_VALID_O <= evt_fire;
         if (evt_fire) begin
            CMD_EVT_O.opcode <= phase_r == PH_OPC ? byte_v : opcode_r;
            CMD_EVT_O.addr <= addr_done ? addr_nxt : 24'h0;
            CMD_EVT_O.cls <= cls_now;
            CMD_EVT_O.state <= dev_state;
            CMD_EVT_O.accepted <= evt_ok;
            CMD_EVT_O.data_unsure <= cls_now == CL_READ && dev_state == ST_ERASE_SUSP && same_sect;
         end
      end
   end

   // xip entry and exit; boot load after reset release, pin reset, confirm bit
   logic boot_r, xip_nv;
   assign xip_nv = NVCFG_XIP_I != NVCFG_XIP_OFF;
   always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         boot_r <= 1'b1;
         xip_r <= 1'b0;
         vcr3_r <= 1'b1;
      end else if (CE_I) begin
         if (boot_r) begin
            boot_r <= 1'b0;
            xip_r <= xip_nv;
         end else if (rst_pin_low && (PROTO_WIDTH_I != PROTO_QUAD || !sel_low)) begin
            xip_r <= xip_nv;
            vcr3_r <= 1'b1;
         end else if (clk_rise && phase_r == PH_DUMMY) begin
            // only line zero counts; the other lines are don't care here
            if (io_s[0]) begin
               xip_r <= 1'b0;
               vcr3_r <= 1'b1;
            end else if (!vcr3_r) begin
               xip_r <= 1'b1;
            end
         end else if (byte_fire && phase_r == PH_DATA && opcode_r == OPC_WR_VCFG) begin
            vcr3_r <= byte_v[VCFG_XIP_BIT];
         end
      end
   end
   assign EXECUTE_IN_PLACE_O = xip_r;
   assign VCFG_XIP_N_O = vcr3_r;

   // crc engine: address requests out, data bytes back through the fifo
   logic [63:0] crc_r, res_r, crc_nxt;
   logic [31:0] req_addr_r, cur_r, last_r;
   logic req_done_r, fail_r, fifo_valid, pop;
   logic [7:0] fifo_data;
   assign crc_nxt = crc_byte(crc_r, fifo_data);
   assign pop = crc_busy_r && fifo_valid;
   always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         crc_busy_r <= 1'b0;
         crc_r <= CRC_INIT;
         res_r <= 64'h0;
         fail_r <= 1'b0;
         req_addr_r <= 32'h0;
         cur_r <= 32'h0;
         last_r <= 32'h0;
         req_done_r <= 1'b1;
      end else if (CE_I) begin
         if (crc_go) begin
            crc_busy_r <= 1'b1;
            crc_r <= CRC_INIT;
            res_r <= 64'h0;
            fail_r <= 1'b0;
            req_addr_r <= crc_whole_r ? 32'h0 : start_r;
            cur_r <= crc_whole_r ? 32'h0 : start_r;
            last_r <= crc_whole_r ? DEV_LAST_ADDR : stop_r;
            req_done_r <= 1'b0;
         end else if (crc_busy_r) begin
            if (ARRAY_ADDR_VALID_O && ARRAY_ADDR_READY_I) begin
               req_addr_r <= req_addr_r + 32'h1;
               if (req_addr_r == last_r) req_done_r <= 1'b1;
            end
            if (pop) begin
               crc_r <= crc_nxt;
               cur_r <= cur_r + 32'h1;
               if (cur_r == last_r) begin
                  crc_busy_r <= 1'b0;
                  fail_r <= crc_nxt != exp_r;
                  if (crc_nxt != exp_r) res_r <= crc_nxt;
               end
            end
         end
      end
   end
   assign ARRAY_ADDR_O = req_addr_r;
   assign ARRAY_ADDR_VALID_O = crc_busy_r && !req_done_r;
   assign CRC_BUSY_O = crc_busy_r;
   assign FLAG_CRC_FAIL_O = fail_r;
   assign CRC_RESULT_REG_O = res_r;

   // returning array data buffered; the source stalls on a full fifo
   crc_byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_i(CORE_CLK_I), .rst_i(SYS_RST_I), .en_i(CE_I),
      .in_data_i(ARRAY_DATA_I), .in_valid_i(ARRAY_DATA_VALID_I), .in_ready_o(ARRAY_DATA_READY_O),
      .out_data_o(fifo_data), .out_valid_o(fifo_valid), .out_ready_i(pop)
   );

   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (SYS_RST_I);
   a_single_state: assert property ($onehot(dev_state)) else $error("state not one-hot");
   a_crc_start_sel: assert property ($rose(crc_busy_r) |-> $past(sel_rise)) else $error("crc began mid frame");
   a_crc_res_clear: assert property ($rose(crc_busy_r) |-> res_r == 64'h0 && !fail_r) else $error("result kept");
   a_status_always: assert property (CMD_EVT_VALID_O && CMD_EVT_O.cls == CL_STATUS |-> CMD_EVT_O.accepted)
      else $error("status read refused");
   a_erase_standby: assert property (CMD_EVT_VALID_O && CMD_EVT_O.cls == CL_ERASE |->
      CMD_EVT_O.accepted == (CMD_EVT_O.state == ST_STANDBY)) else $error("erase gating wrong");
   a_writenv_standby: assert property (CMD_EVT_VALID_O && CMD_EVT_O.cls == CL_WRITE_NV |->
      CMD_EVT_O.accepted == (CMD_EVT_O.state == ST_STANDBY)) else $error("nv write gating wrong");
   a_suspend_busy: assert property (CMD_EVT_VALID_O && CMD_EVT_O.cls == CL_SUSPEND |->
      CMD_EVT_O.accepted == (CMD_EVT_O.state == ST_BUSY)) else $error("suspend gating wrong");
   a_read_busy: assert property (CMD_EVT_VALID_O && CMD_EVT_O.cls == CL_READ |->
      CMD_EVT_O.accepted == (CMD_EVT_O.state != ST_BUSY)) else $error("read gating wrong");
   a_prog_sector: assert property (CMD_EVT_VALID_O && CMD_EVT_O.accepted && CMD_EVT_O.cls == CL_PROG &&
      CMD_EVT_O.state == ST_ERASE_SUSP |-> CMD_EVT_O.addr[SECTOR_LSB +: SECT_W] != $past(SUSP_SECTOR_I))
      else $error("program into suspended sector");
   a_xip_exit_vcr: assert property ($fell(xip_r) |-> vcr3_r) else $error("vcr bit not restored");
endmodule : flash_state_gating_xip_crc

// byte fifo with valid/ready on both sides
module crc_byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic en_i,
   input wire logic [WIDTH-1:0] in_data_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   output logic [WIDTH-1:0] out_data_o,
   output logic out_valid_o,
   input wire logic out_ready_i
);
   localparam int AW = $clog2(DEPTH);
   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");
   end
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_r, rd_r;
   assign in_ready_o = (wr_r - rd_r) != (AW + 1)'(DEPTH);
   assign out_valid_o = wr_r != rd_r;
   assign out_data_o = mem[rd_r[AW-1:0]];
   // pointers carry a wrap bit so full and empty differ
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         wr_r <= '0;
         rd_r <= '0;
      end else if (en_i) begin
         if (in_valid_i && in_ready_o) wr_r <= wr_r + 1'b1;
         if (out_valid_o && out_ready_i) rd_r <= rd_r + 1'b1;
      end
   end
   always_ff @(posedge clk_i) begin
      if (en_i && in_valid_i && in_ready_o) mem[wr_r[AW-1:0]] <= in_data_i;
   end
endmodule : crc_byte_fifo
